// file: core/tpwm_cfg.svh
`ifndef TPWM_CFG_SVH
`define TPWM_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define TPWM_IDX_CTRL_A      8'h2F
`define TPWM_IDX_CTRL_B      8'h33
`define TPWM_IDX_COUNT       8'h32
`define TPWM_IDX_CMP_A       8'h36
`define TPWM_IDX_CMP_B       8'h29
`define TPWM_IDX_FLAGS       8'h35

// ----------------------------------------------------------------------------
// Reset values, masks and field positions
// ----------------------------------------------------------------------------
`define TPWM_REG_RST         8'h00
`define TPWM_CTRL_A_WMASK    8'hF3
`define TPWM_WGS2_BIT        3
`define TPWM_FLAG_OVF        0
`define TPWM_FLAG_MFA        1
`define TPWM_FLAG_MFB        2

// ----------------------------------------------------------------------------
// Counter limits, modes and output modes
// ----------------------------------------------------------------------------
`define TPWM_MAX             8'hFF
`define TPWM_BOTTOM          8'h00
`define TPWM_WGS_FAST_MAX    3'h3
`define TPWM_WGS_FAST_CMP    3'h7
`define TPWM_WGS_PHASE_MAX   3'h1
`define TPWM_WGS_PHASE_CMP   3'h5
`define TPWM_OM_OFF          2'h0
`define TPWM_OM_TOGGLE       2'h1
`define TPWM_OM_NONINV       2'h2
`define TPWM_OM_INV          2'h3

// ----------------------------------------------------------------------------
// Periods in ticks with a TOP of MAX, and bus answers
// ----------------------------------------------------------------------------
`define TPWM_FAST_PERIOD     10'h100
`define TPWM_PHASE_PERIOD    10'h1FE
`define TPWM_RESP_OKAY       2'h0
`define TPWM_RESP_SLVERR     2'h2
`define TPWM_ADDR_W          12

`endif

// file: core/tpwm_pkg.sv
package tpwm_pkg;

   // ----------------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------------
   // Field layout of the first control register
   typedef struct packed {
      logic [1:0] out_mode_a;
      logic [1:0] out_mode_b;
      logic [1:0] rsvd;
      logic [1:0] wave_gen_select;
   } tpwm_ctrl_a_t;

   // Counting direction, one bit so trivially Gray
   typedef enum logic {
      TPWM_UP   = 1'b0,
      TPWM_DOWN = 1'b1
   } tpwm_dir_t;

endpackage : tpwm_pkg

// file: core/tpwm_top.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_cfg.svh"

// How it works
// - Select 3 or 7 runs fast PWM; TOP is MAX or compare A.
// - Fast PWM counts up to TOP, then clears to BOTTOM next tick.
// - Fast PWM: mode 2 clears on match, sets at BOTTOM; mode 3 inverse.
// - Fast PWM sets the overflow flag whenever the counter reaches TOP.
// - Fast PWM toggle on channel A needs select bit 2; channel B lacks it.
// - Fast PWM with TOP of MAX repeats every 256 ticks.
// - Compare A at BOTTOM gives one-tick spike; at MAX a constant level.
// - Compares are double buffered in PWM modes; toggle with compare zero halves the tick.
// - Select 1 or 5 runs phase-correct PWM; TOP is MAX or compare A.
// - Phase-correct holds TOP one tick, then counts down.
// - Phase-correct non-inverting clears on up match, sets on down match.
// - Phase-correct inverting sets on up match, clears on down match.
// - Phase-correct sets the overflow flag whenever the counter reaches BOTTOM.
// - Phase-correct toggle on channel A needs select bit 2; B lacks it.
// - Phase-correct with TOP of MAX repeats every 510 ticks.
// - Phase-correct compare at BOTTOM gives constant low, at MAX constant high.
// - Phase-correct at TOP takes the up-match result unless compare equals TOP.
// - Phase-correct still applies a missed up-count match at TOP.
// - Everything runs on aclk; the tick is only an enable condition.
// - Control A: modes A 7:6, B 5:4, zero 3:2, select 1:0, reset zero.
// - Select bit 2 lives in the second control register.
// - Compare equal to TOP with mode bit 1 set: match ignored, TOP action kept.
// - Mode 0 leaves the wave output alone; wave outputs reset to zero.
module tpwm_top
   import tpwm_pkg::*;
(
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    timer_tick,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [`TPWM_ADDR_W-1:0] awaddr,
   input  wire logic [2:0]              awprot,
   input  wire logic                    wvalid,
   output logic                         wready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   output logic                         bvalid,
   input  wire logic                    bready,
   output logic [1:0]                   bresp,
   input  wire logic                    arvalid,
   output logic                         arready,
   input  wire logic [`TPWM_ADDR_W-1:0] araddr,
   input  wire logic [2:0]              arprot,
   output logic                         rvalid,
   input  wire logic                    rready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         wave_out_a,
   output logic                         wave_out_b
);

   // ----------------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------------
   tpwm_ctrl_a_t       timer_wave_control_a;
   logic               wave_gen_select_bit2;
   logic [7:0]         count_value;
   tpwm_dir_t          dir;
   logic [1:0][7:0]    cmp_buf;
   logic [1:0][7:0]    cmp_act;
   logic               overflow_flag;
   logic [1:0]         match_flag;
   logic [1:0]         wave;
   logic               match_block;
   logic [`TPWM_ADDR_W-1:0] waddr_q;
   logic [7:0]         wdata_q;
   logic               wlane_q;

   // ----------------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------------
   wire        write_go  = !awready && !wready && !bvalid;
   wire        w_hi_zero = (waddr_q[`TPWM_ADDR_W-1:10] == 2'h0);
   wire [7:0]  w_idx     = waddr_q[9:2];
   wire        w_ctrl_a  = write_go && wlane_q && w_hi_zero && (w_idx == `TPWM_IDX_CTRL_A);
   wire        w_ctrl_b  = write_go && wlane_q && w_hi_zero && (w_idx == `TPWM_IDX_CTRL_B);
   wire        w_count   = write_go && wlane_q && w_hi_zero && (w_idx == `TPWM_IDX_COUNT);
   wire        w_cmp_a   = write_go && wlane_q && w_hi_zero && (w_idx == `TPWM_IDX_CMP_A);
   wire        w_cmp_b   = write_go && wlane_q && w_hi_zero && (w_idx == `TPWM_IDX_CMP_B);
   wire        w_flags   = write_go && wlane_q && w_hi_zero && (w_idx == `TPWM_IDX_FLAGS);
   wire        w_mapped  = w_hi_zero && (w_idx == `TPWM_IDX_CTRL_A || w_idx == `TPWM_IDX_CTRL_B ||
                           w_idx == `TPWM_IDX_COUNT || w_idx == `TPWM_IDX_CMP_A ||
                           w_idx == `TPWM_IDX_CMP_B || w_idx == `TPWM_IDX_FLAGS);
   wire        r_hi_zero = (araddr[`TPWM_ADDR_W-1:10] == 2'h0);
   wire [7:0]  r_idx     = araddr[9:2];
   // Reserved bits 3:2 of control A are never stored, so they read zero
   wire [7:0]  r_byte    =
      !r_hi_zero                    ? 8'h00 :
      (r_idx == `TPWM_IDX_CTRL_A)   ? (timer_wave_control_a & `TPWM_CTRL_A_WMASK) :
      (r_idx == `TPWM_IDX_CTRL_B)   ? {4'h0, wave_gen_select_bit2, 3'h0} :
      (r_idx == `TPWM_IDX_COUNT)    ? count_value :
      (r_idx == `TPWM_IDX_CMP_A)    ? cmp_buf[0] :
      (r_idx == `TPWM_IDX_CMP_B)    ? cmp_buf[1] :
      (r_idx == `TPWM_IDX_FLAGS)    ? {5'h00, match_flag[1], match_flag[0], overflow_flag} :
                                      8'h00;
   wire        r_mapped  = r_hi_zero && (r_idx == `TPWM_IDX_CTRL_A || r_idx == `TPWM_IDX_CTRL_B ||
                           r_idx == `TPWM_IDX_COUNT || r_idx == `TPWM_IDX_CMP_A ||
                           r_idx == `TPWM_IDX_CMP_B || r_idx == `TPWM_IDX_FLAGS);

   // ----------------------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------------------
   wire [2:0]  wgs       = {wave_gen_select_bit2, timer_wave_control_a.wave_gen_select};
   wire        is_fast   = (wgs == `TPWM_WGS_FAST_MAX) || (wgs == `TPWM_WGS_FAST_CMP);
   wire        is_phase  = (wgs == `TPWM_WGS_PHASE_MAX) || (wgs == `TPWM_WGS_PHASE_CMP);
   wire        is_pwm    = is_fast || is_phase;
   wire [7:0]  top_val   = (is_pwm && wave_gen_select_bit2) ? cmp_act[0] : `TPWM_MAX;
   wire [7:0]  top_new   = (is_pwm && wave_gen_select_bit2) ? cmp_buf[0] : `TPWM_MAX;
   wire        at_top    = (count_value == top_val);
   wire        at_bot    = (count_value == `TPWM_BOTTOM);
   // tick is an enable term only
   wire        tick      = timer_tick;
   wire        ovf_evt   = tick && (is_fast  ? at_top :
                                    is_phase ? (at_bot && dir == TPWM_DOWN) :
                                               (count_value == `TPWM_MAX));
   wire [1:0][1:0] mode  = {timer_wave_control_a.out_mode_b, timer_wave_control_a.out_mode_a};
   // toggle only on channel A with select bit 2
   wire [1:0]  tog_ok    = {1'b0, (mode[0] == `TPWM_OM_TOGGLE) && wave_gen_select_bit2};
   wire [1:0]  match;
   wire [1:0]  next_wave;

   // ----------------------------------------------------------------------------
   // Per channel compare and waveform
   // ----------------------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
         wire com1      = mode[ch][1];
         wire up_res    = mode[ch][0];
         wire cmp_top   = (cmp_act[ch] == top_val);
         wire new_top   = (cmp_buf[ch] == top_new);
         assign match[ch] = tick && !match_block && (count_value == cmp_act[ch]);
         // at TOP take up result unless compare sits at TOP; TOP action kept
         wire ph_top    = is_phase && tick && at_top && dir == TPWM_UP && com1;
         // up match gives up result, down match the opposite; BOTTOM counts as up
         wire ph_match  = is_phase && match[ch] && com1 && !at_top;
         wire ph_upside = (dir == TPWM_UP) || at_bot;
         wire fa_top    = is_fast && tick && at_top && com1;
         // match ignored when compare equals TOP
         wire fa_match  = is_fast && match[ch] && com1 && !cmp_top;
         // extremes by priority, mode 0 holds
         assign next_wave[ch] =
            ph_top               ? (new_top ? ~up_res : up_res) :
            ph_match             ? (ph_upside ? up_res : ~up_res) :
            fa_top               ? ~up_res :
            fa_match             ? up_res :
            (is_pwm && match[ch] && tog_ok[ch]) ? ~wave[ch] :
                                   wave[ch];

         // double buffered compare, loaded at TOP in PWM modes
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cmp_act[ch] <= `TPWM_REG_RST;
            end else if (!is_pwm || (tick && at_top)) begin
               cmp_act[ch] <= cmp_buf[ch];
            end
         end

         // wave output register resets to zero
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               wave[ch] <= 1'b0;
            end else begin
               wave[ch] <= next_wave[ch];
            end
         end

         // Match flag: set wins over a software clear
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               match_flag[ch] <= 1'b0;
            end else if (match[ch]) begin
               match_flag[ch] <= 1'b1;
            end else if (w_flags && wdata_q[`TPWM_FLAG_MFA + ch]) begin
               match_flag[ch] <= 1'b0;
            end
         end
      end
   endgenerate

   assign wave_out_a = wave[0];
   assign wave_out_b = wave[1];

   // ----------------------------------------------------------------------------
   // Counter and direction
   // ----------------------------------------------------------------------------
   logic [7:0] next_count;
   tpwm_dir_t  next_dir;
   always_comb begin
      next_count = count_value;
      next_dir   = dir;
      if (tick) begin
         case ({is_phase, is_fast})
            // clear to BOTTOM on the tick after TOP
            2'b01: begin
               next_count = at_top ? `TPWM_BOTTOM : count_value + 8'h01;
               next_dir   = TPWM_UP;
            end
            // reverse at TOP, reverse at BOTTOM
            2'b10: begin
               if (dir == TPWM_UP) begin
                  if (at_top) begin
                     next_dir   = TPWM_DOWN;
                     next_count = at_bot ? count_value : count_value - 8'h01;
                  end else begin
                     next_count = count_value + 8'h01;
                  end
               end else begin
                  if (at_bot) begin
                     next_dir   = TPWM_UP;
                     next_count = at_top ? count_value : count_value + 8'h01;
                  end else begin
                     next_count = count_value - 8'h01;
                  end
               end
            end
            default: begin
               next_count = count_value + 8'h01;
               next_dir   = TPWM_UP;
            end
         endcase
      end
      // Software write wins over counting
      if (w_count) begin
         next_count = wdata_q;
      end
   end

   // Counter, direction and one-tick match block after a software write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_value <= `TPWM_REG_RST;
         dir         <= TPWM_UP;
         match_block <= 1'b0;
      end else begin
         count_value <= next_count;
         dir         <= next_dir;
         match_block <= w_count || (match_block && !tick);
      end
   end

   // overflow flag, set wins over a software clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_flag <= 1'b0;
      end else if (ovf_evt) begin
         overflow_flag <= 1'b1;
      end else if (w_flags && wdata_q[`TPWM_FLAG_OVF]) begin
         overflow_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------------
   // control fields; mode bits act at once, not buffered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_wave_control_a <= tpwm_ctrl_a_t'(`TPWM_REG_RST);
         wave_gen_select_bit2 <= 1'b0;
         cmp_buf              <= {`TPWM_REG_RST, `TPWM_REG_RST};
      end else begin
         if (w_ctrl_a) begin
            timer_wave_control_a <= tpwm_ctrl_a_t'(wdata_q & `TPWM_CTRL_A_WMASK);
         end
         if (w_ctrl_b) begin
            wave_gen_select_bit2 <= wdata_q[`TPWM_WGS2_BIT];
         end
         if (w_cmp_a) begin
            cmp_buf[0] <= wdata_q;
         end
         if (w_cmp_b) begin
            cmp_buf[1] <= wdata_q;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------------------
   // Address and data are taken independently; response once both are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= `TPWM_RESP_OKAY;
         waddr_q <= '0;
         wdata_q <= 8'h00;
         wlane_q <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            waddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            wready  <= 1'b0;
            wdata_q <= wdata[7:0];
            wlane_q <= wstrb[0];
         end
         if (write_go) begin
            bvalid <= 1'b1;
            bresp  <= w_mapped ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Reads answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `TPWM_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {24'h00_0000, r_byte};
         rresp   <= r_mapped ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Helper: ticks since the last overflow, and overflows since a disturbance
   logic [9:0] per_cnt;
   logic [1:0] per_seen;
   wire        disturb = w_ctrl_a || w_ctrl_b || w_count;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         per_cnt  <= 10'h000;
         per_seen <= 2'h0;
      end else begin
         per_cnt  <= ovf_evt ? 10'h000 : (tick ? per_cnt + 10'h001 : per_cnt);
         per_seen <= disturb ? 2'h0 : ((ovf_evt && per_seen != 2'h2) ? per_seen + 2'h1 : per_seen);
      end
   end

   chk_fast_wrap_bottom: assert property (is_fast && tick && at_top && !w_count |=> count_value == 8'h00)
      else $error("fast count did not clear after TOP");
   chk_fast_ovf_top: assert property (is_fast && tick && at_top |=> overflow_flag)
      else $error("fast overflow flag not set at TOP");
   chk_fast_set_bottom: assert property (is_fast && tick && at_top && mode[0] == 2'h2 |=> wave_out_a)
      else $error("non-inverting output not set at BOTTOM");
   chk_fast_clr_match: assert property (is_fast && match[1] && mode[1] == 2'h2 && cmp_act[1] != top_val
      |=> !wave_out_b)
      else $error("non-inverting output not cleared on match");
   chk_toggle_a_match: assert property (is_pwm && match[0] && tog_ok[0]
      |=> wave_out_a != $past(wave_out_a))
      else $error("toggle mode did not toggle output A");
   chk_no_toggle_b: assert property (is_pwm && !mode[1][1] |=> wave_out_b == $past(wave_out_b))
      else $error("channel B moved without a PWM mode");
   chk_phase_top_hold: assert property (is_phase && tick && dir == TPWM_UP && at_top && !at_bot && !w_count
      |=> dir == TPWM_DOWN && count_value == $past(count_value) - 8'h01)
      else $error("phase count did not turn after one tick at TOP");
   chk_phase_ovf_bottom: assert property (is_phase && tick && at_bot && dir == TPWM_DOWN |=> overflow_flag)
      else $error("phase overflow flag not set at BOTTOM");
   chk_phase_up_clear: assert property (is_phase && match[0] && mode[0] == 2'h2 && dir == TPWM_UP && !at_top
      |=> !wave_out_a)
      else $error("phase output not cleared on up match");
   chk_cmp_buf_load: assert property (is_pwm && tick && at_top |=> cmp_act[0] == $past(cmp_buf[0]))
      else $error("compare A not loaded at TOP");
   chk_fast_period_ff: assert property (is_fast && !wave_gen_select_bit2 && ovf_evt && per_seen == 2'h2 && !disturb
      |-> per_cnt == `TPWM_FAST_PERIOD - 10'h001)
      else $error("fast period is not 256 ticks");
   chk_phase_period_ff: assert property (is_phase && !wave_gen_select_bit2 && ovf_evt && per_seen == 2'h2 && !disturb
      |-> per_cnt == `TPWM_PHASE_PERIOD - 10'h001)
      else $error("phase period is not 510 ticks");
   chk_rsvd_zero: assert property (timer_wave_control_a.rsvd == 2'h0)
      else $error("reserved control bits not zero");

   cov_fast_wrap:   cover property (is_fast && tick && at_top ##1 count_value == 8'h00);
   cov_phase_turn:  cover property (is_phase && tick && at_top && dir == TPWM_UP ##1 dir == TPWM_DOWN);
   cov_toggle_a:    cover property (is_pwm && match[0] && tog_ok[0]);
   cov_top_no_match: cover property (is_phase && tick && at_top && dir == TPWM_UP && cmp_act[0] != cmp_buf[0]);

endmodule : tpwm_top

`default_nettype wire

// file: test/tpwm_load.sv
`timescale 1ns/100ps
`default_nettype none
module tpwm_load (
   input  wire logic   aclk,
   input  wire logic   clear,
   input  wire logic   wave,
   output logic [15:0] hi,
   output logic [15:0] rises
);
   logic last;
   // Load counts high cycles and rising edges; clear wins so a window opens on any edge
   always_ff @(posedge aclk) begin
      last  <= wave;
      hi    <= clear ? 16'h0000 : hi + {15'h0000, wave};
      rises <= clear ? 16'h0000 : rises + {15'h0000, wave & ~last};
   end
endmodule : tpwm_load
`default_nettype wire

// file: test/tpwm_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpwm_cfg.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin failures++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tpwm_top_tb
   import tpwm_pkg::*;
;
   logic        aclk = 1'b0, aresetn = 1'b0, clr = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, wa, wb;
   logic        tick = 1'b1, slow = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h00000000, rdata, fl;
   logic [15:0] hi_a, hi_b, ri_a, ri_b;
   logic [1:0]  bresp, rresp, rsp;
   int          failures = 0, samples_checked = 0;
   tpwm_top tpwm_top_i (.aclk, .aresetn, .timer_tick(tick), .awvalid, .awready, .awaddr(addr), .awprot(3'h0),
      .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr(addr),
      .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .wave_out_a(wa), .wave_out_b(wb));
   tpwm_load lda_i (.aclk, .clear(clr), .wave(wa), .hi(hi_a), .rises(ri_a));
   tpwm_load ldb_i (.aclk, .clear(clr), .wave(wb), .hi(hi_b), .rises(ri_b));
   always #25 aclk = ~aclk;
   // Tick on every edge, or on every other edge to act as a divide-by-two prescaler
   always @(posedge aclk) tick <= slow ? ~tick : 1'b1;
   // One transfer; each channel dropped at the edge that takes it, only the watchdog bounds the wait
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      addr    <= {2'h0, a, 2'h0};
      wdata   <= {24'h000000, d};
      awvalid <= w;
      wvalid  <= w;
      bready  <= w;
      arvalid <= ~w;
      rready  <= ~w;
      do begin
         @(posedge aclk);
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
         if (arready && arvalid) arvalid <= 1'b0;
      end while ((w ? bvalid : rvalid) !== 1'b1);
      fl = rdata;
      rsp = w ? bresp : rresp;
   endtask : bus
   // Set a mode, settle past double buffering, clear flags, measure len edges; counts read are pre-edge
   task automatic run(input logic [2:0] sel, input logic [7:0] cmp, input logic [1:0] ma, mb, input int len);
      bus(1'b1, `TPWM_IDX_CMP_A, cmp);
      bus(1'b1, `TPWM_IDX_CMP_B, cmp);
      bus(1'b1, `TPWM_IDX_CTRL_B, {4'h0, sel[2], 3'h0});
      bus(1'b1, `TPWM_IDX_CTRL_A, {ma, mb, 2'h0, sel[1:0]});
      repeat (1100) @(posedge aclk);
      bus(1'b1, `TPWM_IDX_FLAGS, 8'h07);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      repeat (len + 1) @(posedge aclk);
   endtask : run
   task automatic t_regs;
      bus(1'b0, `TPWM_IDX_CTRL_A, 8'h00);
      `CHK("ctrl_a reset", 32'h00000000, fl)
      bus(1'b1, `TPWM_IDX_CTRL_A, 8'hFF);
      bus(1'b0, `TPWM_IDX_CTRL_A, 8'h00);
      `CHK("ctrl_a readback", 32'h000000F3, fl)
      bus(1'b0, 8'h00, 8'h00);
      `CHK("unmapped resp", `TPWM_RESP_SLVERR, rsp)
   endtask : t_regs
   // Fast, then phase correct, at mid, bottom and max compare; channel B runs inverted
   task automatic t_pwm;
      logic [7:0]  cm [3] = '{8'h40, 8'h00, 8'hFF};
      logic [15:0] p, e;
      for (int k = 0; k < 6; k++) begin
         p = (k > 2) ? 16'h01FE : 16'h0100;
         e = (k % 3 == 2) ? p : (k > 2) ? {7'h00, cm[k % 3], 1'b0} : {8'h00, cm[k % 3]} + 16'h0001;
         run((k > 2) ? `TPWM_WGS_PHASE_MAX : `TPWM_WGS_FAST_MAX, cm[k % 3], `TPWM_OM_NONINV, `TPWM_OM_INV, p);
         `CHK("high a", e, hi_a)
         `CHK("high b", p - e, hi_b)
         `CHK("rises a", {15'h0000, k == 0 || k == 1 || k == 3}, ri_a)
         bus(1'b0, `TPWM_IDX_FLAGS, 8'h00);
         `CHK("overflow", 1'b1, fl[`TPWM_FLAG_OVF])
      end
   endtask : t_pwm
   task automatic t_toggle;
      run(`TPWM_WGS_FAST_CMP, 8'h00, `TPWM_OM_TOGGLE, `TPWM_OM_TOGGLE, 256);
      `CHK("toggle rises", 16'h0080, ri_a)
      `CHK("b no toggle", 16'h0000, ri_b)
      run(`TPWM_WGS_FAST_MAX, 8'h40, `TPWM_OM_TOGGLE, `TPWM_OM_NONINV, 256);
      `CHK("a no toggle", 16'h0000, ri_a)
   endtask : t_toggle
   // Half-rate tick: each count lasts two edges, so a period is 512 edges and 65 ticks high is 130 edges
   task automatic t_tick;
      slow <= 1'b1;
      run(`TPWM_WGS_FAST_MAX, 8'h40, `TPWM_OM_NONINV, `TPWM_OM_INV, 512);
      `CHK("tick high a", 16'h0082, hi_a)
      `CHK("tick high b", 16'h017E, hi_b)
      `CHK("tick rises a", 16'h0001, ri_a)
      slow <= 1'b0;
   endtask : t_tick
   task automatic finish_test;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   // Two reset edges, then the scenarios
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_pwm;
      t_toggle;
      t_tick;
      finish_test;
   end
   // Watchdog well above the roughly 13k cycles the scenarios take
   initial begin
      repeat (40000) @(posedge aclk);
      failures++;
      finish_test;
   end
endmodule : tpwm_top_tb
`default_nettype wire
